//--- logic/ibc_bus_control.sv
/*
 * bus control register of the two-wire interface with its AXI4-Lite
 * slave, mode decode, hardware mode updates and pin gating.
 * assumes a neighbouring shift engine supplies pin drive requests and
 * the arbitration-lost pulse, and consumes start/stop requests.
 */
// Notes on behaviour
// - interface enable bit 7 connects the module to scl and sda.
// - with enable set, mode and data registers are accessible.
// - with enable clear, module halts, pins released, address registers accessible.
// - interrupt enable bit 6 lets the request flag raise the interrupt.
// - master and transmit bits: 00 slave rx, 01 slave tx, 10 master rx, 11 master tx.
// - losing arbitration as master clears master and transmit bits.
// - slave receive: first frame read/write bit sets the direction.
// - after a hardware mode change, software reads before new master and transmit writes take effect.
// - transmit bit written mid-transfer changes only after the frame and acknowledge.
// - master mode sets the request flag at the ninth clock rising edge.
`timescale 1ns/1ps
module ibc_bus_control (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             scl_out,
	output logic             scl_oe,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic        core_scl_drive,
	input  wire logic        core_sda_drive,
	input  wire logic        arbitration_lost,
	output logic             start_request,
	output logic             stop_request,
	output logic [1:0]       operating_mode,
	output logic [7:0]       mode_value,
	output logic [7:0]       data_value,
	output logic [7:0]       own_address,
	output logic [7:0]       second_address,
	output logic             irq
);
	typedef struct packed {
		logic        have_aw;
		logic [4:0]  awaddr;
		logic        have_w;
		logic [7:0]  wdata;
		logic        wstrb0;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        enable;
		logic        int_en;
		logic        master;
		logic        transmit;
		logic        irq_flag;
		logic        hw_changed;
		logic        pend_valid;
		logic        pend_trs;
		logic        start_req;
		logic        stop_req;
		logic        scl_oe;
		logic        sda_oe;
		logic        irq;
		logic [7:0]  mode_r;
		logic [7:0]  data_r;
		logic [7:0]  slave_address_register;
		logic [7:0]  second_slave_address_register;
	} ibc_ctrl_s;

	ibc_ctrl_s s;
	ibc_ctrl_s next_s;
	ibc_line_if line ();

	ibc_line_watch u_watch (
		.aclk    (aclk),
		.aresetn (aresetn),
		.scl_in  (scl_in),
		.sda_in  (sda_in),
		.line    (line.src)
	);

	// which group an address falls in; gating by the enable bit
	function automatic ibc_pkg::ibc_hit_e decode(input logic [4:0] addr);
		case (addr)
			ibc_pkg::OFF_BUS_CONTROL:   decode = ibc_pkg::REG_CTRL;
			ibc_pkg::OFF_MODE_REGISTER: decode = ibc_pkg::REG_BYTE;
			ibc_pkg::OFF_DATA_REGISTER: decode = ibc_pkg::REG_BYTE;
			ibc_pkg::OFF_SLAVE_ADDR:    decode = ibc_pkg::REG_BLOCK;
			ibc_pkg::OFF_SECOND_ADDR:   decode = ibc_pkg::REG_BLOCK;
			default:                    decode = ibc_pkg::REG_NONE;
		endcase
	endfunction

	function automatic logic allowed(input ibc_pkg::ibc_hit_e hit, input logic en);
		case (hit)
			ibc_pkg::REG_CTRL:  allowed = 1'b1;
			ibc_pkg::REG_BYTE:  allowed = en;
			ibc_pkg::REG_BLOCK: allowed = !en;
			default:            allowed = 1'b0;
		endcase
	endfunction

	always_comb begin
		logic [7:0] wd;
		logic [7:0] ctrl;
		wd = s.wdata;
		next_s = s;
		next_s.start_req = 1'b0;
		next_s.stop_req = 1'b0;
		ctrl = {s.enable, s.int_en, s.master, s.transmit, 1'b0, line.busy, s.irq_flag, 1'b1};

		if (s_axi_awvalid && s_axi_awready) begin
			next_s.have_aw = 1'b1;
			next_s.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_s.have_w = 1'b1;
			next_s.wdata = s_axi_wdata[7:0];
			next_s.wstrb0 = s_axi_wstrb[0];
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end

		if (s.have_aw && s.have_w && !s.bvalid) begin
			next_s.have_aw = 1'b0;
			next_s.have_w = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = allowed(decode(s.awaddr), s.enable) ? ibc_pkg::RESP_OKAY : ibc_pkg::RESP_SLVERR;
			if (allowed(decode(s.awaddr), s.enable) && s.wstrb0) begin
				case (s.awaddr)
					ibc_pkg::OFF_BUS_CONTROL: begin
						next_s.enable = wd[ibc_pkg::BIT_INTERFACE_ENABLE];
						next_s.int_en = wd[ibc_pkg::BIT_INTERRUPT_ENABLE];
						if (!s.hw_changed) begin
							next_s.master = wd[ibc_pkg::BIT_MASTER_SELECT];
							if (line.in_frame && wd[ibc_pkg::BIT_TRANSMIT_SELECT] != s.transmit) begin
								next_s.pend_valid = 1'b1;
								next_s.pend_trs = wd[ibc_pkg::BIT_TRANSMIT_SELECT];
							end else begin
								next_s.pend_valid = 1'b0;
								next_s.transmit = wd[ibc_pkg::BIT_TRANSMIT_SELECT];
							end
						end
						if (!wd[ibc_pkg::BIT_IRQ_FLAG]) begin
							next_s.irq_flag = 1'b0;
						end
						// busy bit is write-locked in slave mode
						if (s.master && s.enable && !wd[ibc_pkg::BIT_START_STOP]) begin
							next_s.start_req = wd[ibc_pkg::BIT_BUS_BUSY] && s.transmit;
							next_s.stop_req = !wd[ibc_pkg::BIT_BUS_BUSY];
						end
					end
					ibc_pkg::OFF_MODE_REGISTER: next_s.mode_r = wd;
					ibc_pkg::OFF_DATA_REGISTER: next_s.data_r = wd;
					ibc_pkg::OFF_SLAVE_ADDR:    next_s.slave_address_register = wd;
					ibc_pkg::OFF_SECOND_ADDR:   next_s.second_slave_address_register = wd;
					default:                    next_s.slave_address_register = s.slave_address_register;
				endcase
			end
		end

		if (s_axi_arvalid && s_axi_arready) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = 32'h0000_0000;
			next_s.rresp = ibc_pkg::RESP_SLVERR;
			if (allowed(decode(s_axi_araddr), s.enable)) begin
				next_s.rresp = ibc_pkg::RESP_OKAY;
				case (s_axi_araddr)
					ibc_pkg::OFF_BUS_CONTROL: begin
						next_s.rdata[7:0] = ctrl;
						next_s.hw_changed = 1'b0;
					end
					ibc_pkg::OFF_MODE_REGISTER: next_s.rdata[7:0] = s.mode_r;
					ibc_pkg::OFF_DATA_REGISTER: next_s.rdata[7:0] = s.data_r;
					ibc_pkg::OFF_SLAVE_ADDR:    next_s.rdata[7:0] = s.slave_address_register;
					ibc_pkg::OFF_SECOND_ADDR:   next_s.rdata[7:0] = s.second_slave_address_register;
					default:                    next_s.rdata[7:0] = 8'h00;
				endcase
			end
		end

		// hardware events follow software so that hardware wins over a write in the same cycle
		if (line.frame_done && s.pend_valid) begin
			next_s.transmit = s.pend_trs;
			next_s.pend_valid = 1'b0;
		end
		if (s.enable && s.master && arbitration_lost) begin
			next_s.master = 1'b0;
			next_s.transmit = 1'b0;
			next_s.pend_valid = 1'b0;
			next_s.hw_changed = 1'b1;
		end
		if (s.enable && !s.master && !s.transmit && line.rw_valid) begin
			next_s.transmit = line.rw_bit;
			next_s.hw_changed = 1'b1;
		end
		if (s.enable && s.master && line.scl_rise9) begin
			next_s.irq_flag = 1'b1;
		end

		// pins released while halted
		next_s.scl_oe = next_s.enable && core_scl_drive;
		next_s.sda_oe = next_s.enable && core_sda_drive;
		next_s.irq = next_s.int_en && next_s.irq_flag;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign line.enable = s.enable;

	assign s_axi_awready = !s.have_aw;
	assign s_axi_wready = !s.have_w;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	// open-drain: only ever pulls low
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = s.scl_oe;
	assign sda_oe = s.sda_oe;
	assign start_request = s.start_req;
	assign stop_request = s.stop_req;
	assign operating_mode = {s.master, s.transmit};
	assign mode_value = s.mode_r;
	assign data_value = s.data_r;
	assign own_address = s.slave_address_register;
	assign second_address = s.second_slave_address_register;
	assign irq = s.irq;
endmodule

//--- logic/ibc_pkg.sv
/*
 * shared constants of the bus control block: register map, field
 * positions, reset values and frame figures.
 * assumes a 32-bit AXI4-Lite register bus and a two-wire serial bus.
 */
package ibc_pkg;
	localparam int unsigned ADDR_W = 5;

	localparam logic [4:0] OFF_BUS_CONTROL   = 5'h00;
	localparam logic [4:0] OFF_MODE_REGISTER = 5'h04;
	localparam logic [4:0] OFF_DATA_REGISTER = 5'h08;
	localparam logic [4:0] OFF_SLAVE_ADDR    = 5'h0C;
	localparam logic [4:0] OFF_SECOND_ADDR   = 5'h10;

	localparam int unsigned BIT_INTERFACE_ENABLE = 7;
	localparam int unsigned BIT_INTERRUPT_ENABLE = 6;
	localparam int unsigned BIT_MASTER_SELECT    = 5;
	localparam int unsigned BIT_TRANSMIT_SELECT  = 4;
	localparam int unsigned BIT_BUS_BUSY         = 2;
	localparam int unsigned BIT_IRQ_FLAG         = 1;
	localparam int unsigned BIT_START_STOP       = 0;

	localparam logic [7:0] RST_BUS_CONTROL = 8'h00;
	localparam logic [7:0] RST_BYTE        = 8'h00;

	localparam logic [3:0] FRAME_BITS = 4'h9;
	localparam logic [3:0] RW_BIT_NUM = 4'h8;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		REG_NONE  = 3'h0,
		REG_CTRL  = 3'h1,
		REG_BYTE  = 3'h2,
		REG_BLOCK = 3'h4
	} ibc_hit_e;
endpackage

//--- logic/ibc_line_if.sv
/*
 * carrier for the bus-line events between the line watcher and the
 * control register block. all signals are on aclk.
 */
`timescale 1ns/1ps
interface ibc_line_if;
	logic enable;
	logic start_det;
	logic stop_det;
	logic scl_rise9;
	logic frame_done;
	logic rw_valid;
	logic rw_bit;
	logic busy;
	logic in_frame;

	modport src (input enable, output start_det, stop_det, scl_rise9, frame_done, rw_valid, rw_bit, busy, in_frame);
	modport dst (output enable, input start_det, stop_det, scl_rise9, frame_done, rw_valid, rw_bit, busy, in_frame);
endinterface

//--- logic/ibc_line_watch.sv
/*
 * watches scl and sda: three-stage sampling, start and stop detection,
 * clock counting inside a frame, read/write bit of the first frame.
 * assumes the pins are asynchronous to aclk and far slower than it.
 */
`timescale 1ns/1ps
module ibc_line_watch (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic scl_in,
	input  wire logic sda_in,
	ibc_line_if.src   line
);
	typedef struct packed {
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic       scl_f;
		logic       sda_f;
		logic [3:0] count;
		logic       first;
		logic       busy;
		logic       start_det;
		logic       stop_det;
		logic       scl_rise9;
		logic       frame_done;
		logic       rw_valid;
		logic       rw_bit;
	} ibc_watch_s;

	ibc_watch_s s;
	ibc_watch_s next_s;

	always_comb begin
		next_s = s;
		next_s.scl_s = {s.scl_s[1:0], scl_in};
		next_s.sda_s = {s.sda_s[1:0], sda_in};
		next_s.start_det = 1'b0;
		next_s.stop_det = 1'b0;
		next_s.scl_rise9 = 1'b0;
		next_s.frame_done = 1'b0;
		next_s.rw_valid = 1'b0;
		// a change counts only once stages two and three agree
		if (s.scl_s[1] == s.scl_s[2]) begin
			next_s.scl_f = s.scl_s[2];
		end
		if (s.sda_s[1] == s.sda_s[2]) begin
			next_s.sda_f = s.sda_s[2];
		end
		if (s.scl_f && next_s.scl_f && s.sda_f && !next_s.sda_f) begin
			next_s.start_det = 1'b1;
			next_s.busy = 1'b1;
			next_s.first = 1'b1;
			next_s.count = 4'h0;
		end else if (s.scl_f && next_s.scl_f && !s.sda_f && next_s.sda_f) begin
			next_s.stop_det = 1'b1;
			next_s.busy = 1'b0;
			next_s.first = 1'b0;
			next_s.count = 4'h0;
		end else if (!s.scl_f && next_s.scl_f && s.busy) begin
			next_s.count = s.count + 4'h1;
			if (next_s.count == ibc_pkg::RW_BIT_NUM && s.first) begin
				next_s.rw_valid = 1'b1;
				next_s.rw_bit = next_s.sda_f;
			end
			if (next_s.count == ibc_pkg::FRAME_BITS) begin
				next_s.scl_rise9 = 1'b1;
			end
		end else if (s.scl_f && !next_s.scl_f && s.count == ibc_pkg::FRAME_BITS) begin
			// acknowledge clock has ended: the frame is complete
			next_s.frame_done = 1'b1;
			next_s.first = 1'b0;
			next_s.count = 4'h0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !line.enable) begin
			s <= '0;
			s.scl_s <= 3'h7;
			s.sda_s <= 3'h7;
			s.scl_f <= 1'b1;
			s.sda_f <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign line.start_det = s.start_det;
	assign line.stop_det = s.stop_det;
	assign line.scl_rise9 = s.scl_rise9;
	assign line.frame_done = s.frame_done;
	assign line.rw_valid = s.rw_valid;
	assign line.rw_bit = s.rw_bit;
	assign line.busy = s.busy;
	assign line.in_frame = (s.count != 4'h0);
endmodule

//--- verification/ibc_bus_control_monitor.sv
/* assertion monitor of the bus control block, bound to its ports.
   assumes one clock aclk with synchronous active-low reset. */
`timescale 1ns/1ps
module ibc_bus_control_monitor (
	input logic        aclk,
	input logic        aresetn,
	input logic [4:0]  s_axi_awaddr,
	input logic        s_axi_awvalid,
	input logic        s_axi_awready,
	input logic [31:0] s_axi_wdata,
	input logic        s_axi_wvalid,
	input logic        s_axi_wready,
	input logic        s_axi_bvalid,
	input logic [4:0]  s_axi_araddr,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic        s_axi_rvalid,
	input logic [31:0] s_axi_rdata,
	input logic [1:0]  s_axi_rresp,
	input logic        core_scl_drive,
	input logic        core_sda_drive,
	input logic        arbitration_lost,
	input logic        scl_oe,
	input logic        sda_oe,
	input logic        start_request,
	input logic [1:0]  operating_mode,
	input logic        irq
);
	// en leads the stored enable by one edge, en_d matches it
	logic en, en_d;
	wire  aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	always_ff @(posedge aclk) begin
		en_d <= aresetn && en;
		if (!aresetn)
			en <= 1'b0;
		else if (aw_w && s_axi_awaddr == ibc_pkg::OFF_BUS_CONTROL)
			en <= s_axi_wdata[ibc_pkg::BIT_INTERFACE_ENABLE];
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_reset; $rose(aresetn) |-> operating_mode == 2'h0 && !irq && !scl_oe && !sda_oe; endproperty
	a_reset: assert property (p_reset) else $error("state not cleared at reset");
	property p_pins; en && en_d |=> scl_oe == $past(core_scl_drive) && sda_oe == $past(core_sda_drive); endproperty
	a_pins: assert property (p_pins) else $error("pin drive not passed");
	property p_off; !en && !en_d |=> !scl_oe && !sda_oe; endproperty
	a_off: assert property (p_off) else $error("pins driven while off");
	property p_arb; arbitration_lost && en && en_d && operating_mode[1] |=> operating_mode == 2'h0; endproperty
	a_arb: assert property (p_arb) else $error("mode kept after lost arbitration");
	property p_gated; s_axi_arvalid && s_axi_arready && s_axi_araddr == ibc_pkg::OFF_MODE_REGISTER && !en && !en_d
		|=> s_axi_rresp == ibc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
	a_gated: assert property (p_gated) else $error("mode register open while off");
	property p_wr; aw_w |=> !s_axi_bvalid ##1 s_axi_bvalid; endproperty
	a_wr: assert property (p_wr) else $error("write answer late");
	property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
	a_rd: assert property (p_rd) else $error("read answer late");
	property p_start; start_request |-> operating_mode == 2'h3 && en_d; endproperty
	a_start: assert property (p_start) else $error("start outside master transmit");
	c_arb: cover property (arbitration_lost && operating_mode[1]);
	c_start: cover property (start_request);
	c_irq: cover property ($rose(irq));
endmodule
bind ibc_bus_control ibc_bus_control_monitor i_ibc_bus_control_monitor (.*);

//--- verification/ibc_i2c_peer.sv
/* serial bus peer: pull-up wires and a master framing one byte.
   assumes open-drain enables from the block; scl period 400 ns. */
`timescale 1ns/1ps
module ibc_i2c_peer (
	input  logic scl_oe,
	input  logic sda_oe,
	output logic scl_line,
	output logic sda_line
);
	logic scl_low = 1'b0;
	logic sda_low = 1'b0;
	// pull-ups: a released line reads high, scl stands still between frames
	assign scl_line = !(scl_low || scl_oe);
	assign sda_line = !(sda_low || sda_oe);
	task automatic frame(input logic [7:0] b);
		// offset keeps every pin change off an aclk edge
		#10;
		sda_low = 1'b1;
		#200;
		for (int i = 8; i >= 0; i--) begin
			scl_low = 1'b1;
			#100;
			sda_low = (i > 0) && !b[i - 1];
			#100;
			scl_low = 1'b0;
			#200;
		end
		scl_low = 1'b1;
		#100;
		sda_low = 1'b1;
		#100;
		scl_low = 1'b0;
		#100;
		sda_low = 1'b0;
		#200;
	endtask
endmodule

//--- verification/i2c_bus_control_register_test.sv
/* bench of the bus control block: AXI4-Lite register tasks, modes,
   pin gating, hardware mode updates. assumes the peer and monitor. */
`timescale 1ns/1ps
module i2c_bus_control_register_test;
	localparam logic [1:0] OK  = ibc_pkg::RESP_OKAY;
	localparam logic [1:0] ER  = ibc_pkg::RESP_SLVERR;
	localparam logic [4:0] CTL = ibc_pkg::OFF_BUS_CONTROL;
	localparam logic [4:0] MOD = ibc_pkg::OFF_MODE_REGISTER;
	localparam logic [4:0] SAD = ibc_pkg::OFF_SLAVE_ADDR;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        scl_in, sda_in, scl_out, scl_oe, sda_out, sda_oe, core_scl_drive, core_sda_drive;
	logic        arbitration_lost, start_request, stop_request, irq;
	logic [4:0]  s_axi_awaddr, s_axi_araddr;
	logic [3:0]  s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp, operating_mode;
	logic [7:0]  mode_value, data_value, own_address, second_address;
	int          n_mismatch, compares, n_start, n_stop;
	ibc_bus_control i_ibc_bus_control (.*);
	ibc_i2c_peer i_ibc_i2c_peer (.scl_oe, .sda_oe, .scl_line(scl_in), .sda_line(sda_in));
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	// start pulses last one cycle, so count them as they pass
	always @(posedge aclk) if (start_request === 1'b1) n_start++;
	always @(posedge aclk) if (stop_request === 1'b1) n_stop++;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] r);
		bit aw, w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			aw = aw && !s_axi_awready;
			w = w && !s_axi_wready;
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
		end while (aw || w || !s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(32'(s_axi_bresp), 32'(r));
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] d, input logic [1:0] r);
		bit ar;
		ar = 1'b1;
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			ar = ar && !s_axi_arready;
			s_axi_arvalid <= ar;
		end while (ar || !s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, {24'h00_0000, d});
		chk(32'(s_axi_rresp), 32'(r));
	endtask
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#300000;
		n_mismatch++;
		print_verdict;
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{core_scl_drive, core_sda_drive, arbitration_lost} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(CTL, 8'h01, OK);
		chk({mode_value, data_value, own_address, second_address}, 32'h0);
		rd(MOD, 8'h00, ER);
		wr(ibc_pkg::OFF_DATA_REGISTER, 8'h33, ER);
		wr(SAD, 8'h5a, OK);
		rd(SAD, 8'h5a, OK);
		chk(32'(own_address), 32'h5a);
		wr(ibc_pkg::OFF_SECOND_ADDR, 8'ha5, OK);
		chk(32'(second_address), 32'ha5);
		{core_scl_drive, core_sda_drive} <= 2'h3;
		repeat (3) @(posedge aclk);
		chk(32'({scl_oe, sda_oe}), 32'h0);
		wr(CTL, 8'h81, OK);
		rd(SAD, 8'h00, ER);
		wr(MOD, 8'h0c, OK);
		rd(MOD, 8'h0c, OK);
		wr(ibc_pkg::OFF_DATA_REGISTER, 8'h3c, OK);
		chk(32'(data_value), 32'h3c);
		chk(32'({scl_oe, sda_oe}), 32'h3);
		chk(32'({scl_out, sda_out}), 32'h0);
		{core_scl_drive, core_sda_drive} <= 2'h0;
		$display("done gating");
		for (int m = 0; m < 4; m++) begin
			wr(CTL, {2'h2, m[1:0], 4'h1}, OK);
			chk(32'(operating_mode), 32'(m));
			rd(CTL, {2'h2, m[1:0], 4'h1}, OK);
		end
		wr(CTL, 8'hb4, OK);
		repeat (2) @(posedge aclk);
		chk(32'(n_start), 32'h1);
		chk(32'(n_stop), 32'h0);
		wr(CTL, 8'hb0, OK);
		repeat (2) @(posedge aclk);
		chk(32'(n_stop), 32'h1);
		chk(32'(n_start), 32'h1);
		arbitration_lost <= 1'b1;
		@(posedge aclk);
		arbitration_lost <= 1'b0;
		@(posedge aclk);
		chk(32'(operating_mode), 32'h0);
		wr(CTL, 8'hb1, OK);
		chk(32'(operating_mode), 32'h0);
		rd(CTL, 8'h81, OK);
		wr(CTL, 8'hb1, OK);
		chk(32'(operating_mode), 32'h3);
		$display("done modes");
		fork
			i_ibc_i2c_peer.frame(8'h00);
			begin
				#1510;
				wr(CTL, 8'ha1, OK);
				chk(32'(operating_mode), 32'h3);
			end
		join
		repeat (2) @(posedge aclk);
		chk(32'(operating_mode), 32'h2);
		chk(32'(irq), 32'h0);
		rd(CTL, 8'ha3, OK);
		wr(CTL, 8'he3, OK);
		chk(32'(irq), 32'h1);
		wr(CTL, 8'he1, OK);
		chk(32'(irq), 32'h0);
		wr(CTL, 8'h81, OK);
		i_ibc_i2c_peer.frame(8'ha1);
		chk(32'(operating_mode), 32'h1);
		rd(CTL, 8'h91, OK);
		$display("done frames");
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(CTL, 8'h01, OK);
		chk(32'(operating_mode), 32'h0);
		$display("done reset");
		print_verdict;
	end
endmodule
